/* inc/smp_pkg.sv */
// shared constants for the sector map protection table block
package smp_pkg;
  // ************************************************
  // table geometry
  // ************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] TBL_BASE = 12'h250;
  localparam logic [11:0] TBL_LAST = 12'h25F;
  localparam logic [11:0] SEC4_TYPE_ADDR = 12'h258;
  localparam logic [11:0] SEC4_CNT_ADDR = 12'h259;
  localparam logic [11:0] SEC4_FIRST_ADDR = 12'h25A;
  localparam logic [11:0] SEC4_LAST_ADDR = 12'h25B;
  localparam logic [11:0] SEC5_TYPE_ADDR = 12'h25C;
  localparam logic [11:0] SEC5_CNT_ADDR = 12'h25D;
  localparam logic [11:0] SEC5_FIRST_ADDR = 12'h25E;
  localparam logic [11:0] SEC5_LAST_ADDR = 12'h25F;
  // ************************************************
  // table contents
  // ************************************************
  localparam logic [7:0] SEC4_TYPE_VAL = 8'h03;
  localparam logic [7:0] SEC4_CNT_VAL = 8'h00;
  localparam logic [7:0] SEC4_FIRST_VAL = 8'hFE;
  localparam logic [7:0] SEC4_LAST_VAL = 8'hFE;
  localparam logic [7:0] SEC5_TYPE_VAL = 8'h02;
  localparam logic [7:0] SEC5_CNT_VAL = 8'h02;
  localparam logic [7:0] SEC5_FIRST_VAL = 8'h07;
  localparam logic [7:0] SEC5_LAST_VAL = 8'h0E;
  localparam logic [7:0] UNMAPPED_VAL = 8'hFF;
  // sector type codes and where their sizes live
  localparam logic [7:0] TYPE1_CODE = 8'h01;
  localparam logic [7:0] TYPE2_CODE = 8'h02;
  localparam logic [7:0] TYPE3_CODE = 8'h03;
  localparam logic [7:0] TYPE4_CODE = 8'h04;
  localparam logic [11:0] TYPE1_SIZE_ADDR = 12'h04C;
  localparam logic [11:0] TYPE2_SIZE_ADDR = 12'h04E;
  localparam logic [11:0] TYPE3_SIZE_ADDR = 12'h050;
  localparam logic [11:0] TYPE4_SIZE_ADDR = 12'h052;
  localparam logic [3:0] DENSITY_M = 4'h6;
  // ************************************************
  // bus register map
  // ************************************************
  localparam logic [11:0] REG_ADDR = 12'h000;
  localparam logic [11:0] REG_DATA = 12'h004;
  localparam logic [11:0] REG_POS = 12'h008;
  localparam logic [11:0] REG_INFO = 12'h00C;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  typedef enum logic [1:0]
  {
    SMP_IDLE = 2'b00,
    SMP_FETCH = 2'b01,
    SMP_DONE = 2'b10
  } smp_state_type;
endpackage

/* inc/smp_rom_if.sv */
// lookup port between the table controller and the table memory
interface smp_rom_if;
  logic [11:0] addr;
  logic rd;
  logic [7:0] data;
  logic hit;
  modport ctrl (output addr, output rd, input data, input hit);
  modport rom (input addr, input rd, output data, output hit);
endinterface

/* core/smp_rom.sv */
// registered parameter table memory for the upper map sections
module smp_rom
  import smp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  smp_rom_if.rom port
);
  logic [7:0] lut_data;
  logic lut_hit;
  logic [7:0] data;
  logic hit;

  // ************************************************
  // content, four bytes per section in address order
  // ************************************************
  always_comb
  begin
    lut_hit = 1'b1;
    case (port.addr)
      SEC4_TYPE_ADDR: lut_data = SEC4_TYPE_VAL;
      SEC4_CNT_ADDR: lut_data = SEC4_CNT_VAL;
      SEC4_FIRST_ADDR: lut_data = SEC4_FIRST_VAL;
      SEC4_LAST_ADDR: lut_data = SEC4_LAST_VAL;
      SEC5_TYPE_ADDR: lut_data = SEC5_TYPE_VAL;
      SEC5_CNT_ADDR: lut_data = SEC5_CNT_VAL;
      SEC5_FIRST_ADDR: lut_data = SEC5_FIRST_VAL;
      SEC5_LAST_ADDR: lut_data = SEC5_LAST_VAL;
      default:
      begin
        // no 4-Kbyte uniform section is ever listed
        lut_data = UNMAPPED_VAL;
        lut_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      data <= 8'h00;
      hit <= 1'b0;
    end
    else if (port.rd)
    begin
      data <= lut_data;
      hit <= lut_hit;
    end
  end

  assign port.data = data;
  assign port.hit = hit;
endmodule

/* core/smp_table.sv */
// sector map and protection bit table reachable over an AHB-Lite slave
// How it works
// - byte 258H returns 03H, section four is 32-Kbyte blocks.
// - byte 259H returns 00H, section four holds one block.
// - bytes 25AH and 25BH both return FEH, adder minus two.
// - byte 25CH returns 02H, section five is 8-Kbyte top blocks.
// - byte 25DH returns 02H, section five holds four blocks.
// - byte 25EH returns 07H, first protect bit adder plus seven.
// - byte 25FH returns 0EH, last protect bit adder plus fourteen.
// - in the top section odd bits lock reads, even bits lock writes.
// - type codes 1 to 4 point at size entries 4CH to 52H.
// - protect bits step by one from first to last, one per block, two per block in the top section.
// - uniform 4-Kbyte sectors never appear in any section.
// - each section is one contiguous run of equal-size blocks.
// - sections are listed in ascending address order.
//
// The AHB-Lite slave port and the address map were left to the implementer.
module smp_table
  import smp_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RESET_N,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP
);
  import smp_pkg::*;

  smp_rom_if rom_bus();
  smp_state_type state;
  smp_state_type next_state;
  logic [11:0] lookup_addr;
  logic [7:0] last_data;
  logic last_hit;
  logic [7:0] pos;
  logic pos_valid;
  logic [11:0] size_addr;
  logic [11:0] ph_addr;
  logic ph_write;
  logic [11:0] last_addr;
  logic [11:0] fetch_addr;
  logic [31:0] rdata;

  // ************************************************
  // helpers
  // ************************************************
  // protect bit position for a stored byte; 00H stands for bit zero itself
  function automatic logic [7:0] bit_pos(input logic [7:0] adder);
    logic [7:0] base;
    base = 8'((9'h001 << DENSITY_M) + 9'h001);
    if (adder == 8'h00)
      bit_pos = 8'h00;
    else
      bit_pos = 8'(base + adder);
  endfunction

  function automatic logic [11:0] type_size_addr(input logic [7:0] code);
    case (code)
      TYPE1_CODE: type_size_addr = TYPE1_SIZE_ADDR;
      TYPE2_CODE: type_size_addr = TYPE2_SIZE_ADDR;
      TYPE3_CODE: type_size_addr = TYPE3_SIZE_ADDR;
      TYPE4_CODE: type_size_addr = TYPE4_SIZE_ADDR;
      default: type_size_addr = 12'h000;
    endcase
  endfunction

  // ************************************************
  // bus address phase
  // ************************************************
  wire access = I_HSEL && I_HREADY && (I_HTRANS == HTRANS_NONSEQ || I_HTRANS == HTRANS_SEQ);
  wire addr_wr = ph_write && (ph_addr == REG_ADDR);
  wire data_rd_start = access && !I_HWRITE && (I_HADDR[11:0] == REG_DATA);
  wire read_start = access && !I_HWRITE;

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      ph_addr <= 12'h000;
      ph_write <= 1'b0;
    end
    else if (O_HREADYOUT)
    begin
      ph_addr <= I_HADDR[11:0];
      ph_write <= access && I_HWRITE;
    end
  end

  // ************************************************
  // lookup sequencer
  // ************************************************
  // a read of the data register stalls one cycle while the registered memory answers
  always_comb
  begin
    next_state = state;
    case (state)
      SMP_IDLE: if (data_rd_start) next_state = SMP_FETCH;
      SMP_FETCH: next_state = SMP_DONE;
      // a data read may follow straight on in the last cycle of the one before
      SMP_DONE: next_state = data_rd_start ? SMP_FETCH : SMP_IDLE;
      default: next_state = SMP_IDLE;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      state <= SMP_IDLE;
    else
      state <= next_state;
  end

  // a pointer written just before the read is passed straight to the memory
  assign fetch_addr = addr_wr ? I_HWDATA[11:0] : lookup_addr;
  assign rom_bus.addr = fetch_addr;
  assign rom_bus.rd = data_rd_start;

  smp_rom u_rom
  (
    .i_clk(I_SYS_CLK),
    .i_reset_n(I_RESET_N),
    .port(rom_bus.rom)
  );

  // ************************************************
  // software visible state
  // ************************************************
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      lookup_addr <= TBL_BASE;
    else if (addr_wr)
      lookup_addr <= I_HWDATA[11:0];
    else if (state == SMP_FETCH)
      lookup_addr <= 12'(lookup_addr + 12'h001);
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      last_data <= 8'h00;
      last_hit <= 1'b0;
      last_addr <= 12'h000;
    end
    else if (state == SMP_FETCH)
    begin
      last_data <= rom_bus.data;
      last_hit <= rom_bus.hit;
      last_addr <= lookup_addr;
    end
  end

  // first/last bytes carry adders; decode them for software convenience
  // offsets two and three of a section hold the first and last adders
  wire adder_field = last_addr[1];
  // only the 8-Kbyte top section splits its protect bits into read and write locks
  wire top_section = (last_addr[11:2] == SEC5_TYPE_ADDR[11:2]);
  assign pos = bit_pos(last_data);
  assign pos_valid = last_hit && adder_field;
  wire lock_en = pos_valid && top_section;
  assign size_addr = type_size_addr(last_data);

  // ************************************************
  // read data
  // ************************************************
  always_comb
  begin
    case (I_HADDR[11:0])
      REG_ADDR: rdata = {20'h00000, fetch_addr};
      REG_DATA: rdata = {24'h000000, rom_bus.data};
      // bit 8 flags a read-lock position (odd), bit 9 a write-lock (even)
      REG_POS: rdata = {22'h000000, lock_en && !pos[0], lock_en && pos[0], pos};
      REG_INFO: rdata = {19'h00000, last_hit, size_addr};
      default: rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      O_HRDATA <= 32'h00000000;
    else if (state == SMP_FETCH)
      O_HRDATA <= {24'h000000, rom_bus.data};
    else if (read_start && O_HREADYOUT)
      O_HRDATA <= rdata;
  end
  // read data is loaded at the address phase, or when the memory answers,
  // so that it stands in the last cycle of every data phase

  // data register reads stretch until the memory has answered
  assign O_HREADYOUT = (state == SMP_IDLE) || (state == SMP_DONE);
  assign O_HRESP = 1'b0;
endmodule

/* sim/smp_table_assertions.sv */
// concurrent checks on the bus ports of the sector map table
module smp_assert
  import smp_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RESET_N,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic I_HREADY,
  input wire logic [31:0] O_HRDATA,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP
);
  logic dph_rd;
  logic [11:0] dph_a;
  wire logic take = I_HSEL && I_HREADY && I_HTRANS[1];
  wire logic dread = take && !I_HWRITE && I_HADDR[11:0] == REG_DATA;
  wire logic rd_done = dph_rd && O_HREADYOUT;
  wire logic rd_take = take && !I_HWRITE;
  wire logic rd_wait = dph_rd && !O_HREADYOUT;
  // data phase only moves on once the previous one has finished
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      dph_rd <= 1'b0;
      dph_a <= 12'h000;
    end
    else if (O_HREADYOUT)
    begin
      dph_rd <= take && !I_HWRITE;
      dph_a <= I_HADDR[11:0];
    end
  end
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RESET_N);
  property p_okay; O_HRESP == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bad resp");
  property p_dwait; dread |=> !O_HREADYOUT ##1 O_HREADYOUT; endproperty
  a_dwait: assert property (p_dwait) else $error("data wait");
  property p_fast; take && !dread |=> O_HREADYOUT; endproperty
  a_fast: assert property (p_fast) else $error("extra wait");
  property p_stall; $fell(O_HREADYOUT) |-> $past(dread); endproperty
  a_stall: assert property (p_stall) else $error("stray stall");
  property p_hold; !$past(rd_take) && !$past(rd_wait) |-> $stable(O_HRDATA); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_unmap; rd_done && dph_a > REG_INFO |-> O_HRDATA == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_byte;
    rd_done && dph_a == REG_DATA |-> O_HRDATA[31:8] == 24'h0 &&
      O_HRDATA[7:0] inside {8'h00, 8'h02, 8'h03, 8'h07, 8'h0E, 8'hFE, 8'hFF};
  endproperty
  a_byte: assert property (p_byte) else $error("bad byte");
  property p_addr; rd_done && dph_a == REG_ADDR |-> O_HRDATA[31:12] == 20'h0; endproperty
  a_addr: assert property (p_addr) else $error("addr width");
  // never both locks at once; read-lock only on odd, write-lock only on even positions
  property p_lock;
    rd_done && dph_a == REG_POS |-> !(O_HRDATA[9] && O_HRDATA[8]) &&
      (!O_HRDATA[8] || O_HRDATA[0]) && (!O_HRDATA[9] || !O_HRDATA[0]);
  endproperty
  a_lock: assert property (p_lock) else $error("lock flag parity");
  c_dread: cover property (rd_done && dph_a == REG_DATA);
  c_unmap: cover property (rd_done && dph_a > REG_INFO);
  c_info: cover property (rd_done && dph_a == REG_INFO);
endmodule

/* sim/smp_host.sv */
// bus master standing in for the host controller that reads the table
module smp_host
  import smp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  output logic o_hsel,
  output logic [31:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [31:0] o_hwdata
);
  initial
  begin
    o_hsel = 1'b0;
    o_haddr = 32'h0;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hwdata = 32'h0;
  end
  // protect bit position a reader derives from a stored byte
  function automatic int exp_pos(input logic [7:0] v);
    if (v == 8'h00)
      return 0;
    else
      return (1 << DENSITY_M) + 1 + int'($signed(v));
  endfunction
  // blocks a section holds, from its type code and count byte
  function automatic int blocks_of(input logic [7:0] code, input logic [7:0] n);
    if (code == TYPE4_CODE)
      return (1 << DENSITY_M) - 2;
    else
      return 1 << n;
  endfunction
  // call just after a rising edge; read data is taken at the edge that ends the data phase
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    o_hsel <= 1'b1;
    o_haddr <= {20'h0, a};
    o_htrans <= HTRANS_NONSEQ;
    o_hwrite <= w;
    @(posedge i_clk iff i_hready);
    o_htrans <= 2'h0;
    o_hwdata <= wd;
    @(posedge i_clk iff i_hready);
    rd = i_hrdata;
    // select stays up with an idle transfer so a next call never re-drives it at once;
    // released data lines show the inverse so stale values cannot pass
    o_hwdata <= ~wd;
  endtask
endmodule

/* sim/tb.sv */
// bench for the sector map table: lookup rows, a byte stream, reset and unmapped places
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import smp_pkg::*;
  typedef struct packed {logic [11:0] a; logic [7:0] v;} smp_row_type;
  smp_row_type rows [9] = '{'{12'h258, 8'h03}, '{12'h259, 8'h00}, '{12'h25A, 8'hFE},
    '{12'h25B, 8'hFE}, '{12'h25C, 8'h02}, '{12'h25D, 8'h02}, '{12'h25E, 8'h07},
    '{12'h25F, 8'h0E}, '{12'h257, 8'hFF}};
  logic clk, reset_n, hsel, hwrite, hready;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] got [8];
  int span;
  int err_count = 0;
  int compares = 0;
  smp_table smp_table_i (.I_SYS_CLK(clk), .I_RESET_N(reset_n), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
    .O_HRESP());
  smp_host smp_host_i (.i_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
    .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hwdata(hwdata));
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    smp_host_i.xfer(1'b0, a, 32'h0, rd);
    compares++;
    if (rd !== exp)
    begin
      $display("MISMATCH t=%0t addr %h got %h exp %h", $time, a, rd, exp);
      err_count++;
    end
  endtask
  // expected position word: adders sit at offsets two and three, locks only in the top section
  function automatic logic [31:0] pos_word(input logic [11:0] a, input logic [7:0] v);
    logic [7:0] p;
    logic lock;
    p = 8'(smp_host_i.exp_pos(v));
    lock = a[1] && (a >= 12'h25C);
    return {22'h0, lock && !p[0], lock && p[0], p};
  endfunction
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    err_count++;
    give_verdict();
  end
  initial
  begin
    reset_n = 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    foreach (rows[k])
    begin
      smp_host_i.xfer(1'b1, REG_ADDR, {20'h0, rows[k].a}, rd);
      rdchk(REG_DATA, {24'h0, rows[k].v});
    end
    $display("rows done");
    smp_host_i.xfer(1'b1, REG_ADDR, 32'h00000258, rd);
    for (int k = 0; k < 8; k++)
    begin
      rdchk(REG_DATA, {24'h0, rows[k].v});
      got[k] = rd[7:0];
      if (k == 0)
        rdchk(REG_INFO, 32'h00001050);
      if (k == 2 || k == 5 || k == 6 || k == 7)
        rdchk(REG_POS, pos_word(rows[k].a, rows[k].v));
    end
    for (int s = 0; s < 2; s++)
    begin
      span = smp_host_i.exp_pos(got[4 * s + 3]) - smp_host_i.exp_pos(got[4 * s + 2]) + 1;
      compares++;
      // the top section pairs a read-lock and a write-lock bit per block
      if (span != smp_host_i.blocks_of(got[4 * s], got[4 * s + 1]) * (s + 1))
      begin
        $display("MISMATCH t=%0t section %0d spans %0d bits", $time, s + 4, span);
        err_count++;
      end
    end
    $display("stream done");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdchk(REG_ADDR, 32'h00000250);
    rdchk(REG_DATA, 32'h000000FF);
    rdchk(12'h010, 32'h00000000);
    $display("reset done");
    give_verdict();
  end
endmodule
bind smp_table smp_assert smp_assert_i (.I_SYS_CLK(I_SYS_CLK), .I_RESET_N(I_RESET_N),
  .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
  .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP));
